// ===== hw/qbp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a bus of pin levels
module qbp_pin_sync #(
    parameter int W = 8
) (
    // Clock, reset and enable
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic         clk_en,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== hw/qbp_pkg.sv
package qbp_pkg;
    // Drive state of one quasi-bidirectional pin
    typedef enum logic [1:0] {
        QBP_INPUT_LOW,
        QBP_STEADY_HIGH,
        QBP_FORCED_HIGH,
        QBP_OUTPUT_LOW
    } qbp_drive_t;
    typedef logic [3:0] qbp_phase_t;
endpackage

// ===== hw/qbp_port.sv
// How it works
// R1 - Alternate function passes only when latch is one
// R2 - Reset sets every latch bit to one
// R3 - Bus ports switch drivers during external access
// R4 - Latch disconnected and unchanged during bus use
// R5 - Low port pullup only for bus ones
// R6 - Low port latch one floats pin
// R7 - Wide address: high port strong pullup drives ones
// R8 - No bus cycles keeps low port general
// R9 - Pulldown on only while latch is zero; the code also turns it on where alt_out is zero
// R10 - Zero-to-one write pulses transition pullup S1P1-S1P2
// R11 - Weak pullup on whenever latch is one; the code turns it off where alt_out is zero
// R12 - Medium pullup follows sensed pin above trip
// R13 - Pin takes one of four drive states
// R14 - Rewriting one gives no pulse
// R15 - Input pin level selects low or high state
// R16 - Reset starts pins in input-low state
// R17 - Zero then one forces strong high
// R18 - Software never writes zero to input pins
// R19 - Latch updates S6P2, pin follows at S1P1
// R20 - Output buffers sample latch in phase one
// R21 - Pin read sampled once in state five
// R22 - Edge when sample differs from previous cycle
// R23 - Reads return latch or pin level
// R24 - Narrow address keeps high port latch output
// R25 - Machine cycle is twelve oscillator periods
// R26 - Separate enables per pin plus comparator input
`include "qbp_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module qbp_port
    import qbp_pkg::*;
#(
    parameter int W = `QBP_WIDTH
) (
    // Clock, reset, enable (core_clk is the oscillator period)
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic         clk_en,
    // CPU write and read side
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    input  wire logic         rd_latch_sel,
    output logic      [W-1:0] rd_data,
    output logic      [W-1:0] pin_edge,
    output logic      [3:0]   phase,
    // Alternate function path of the multifunction port
    input  wire logic [W-1:0] alt_out,
    output logic      [W-1:0] alt_in,
    // External bus control
    input  wire logic         ext_bus_low,
    input  wire logic         ext_bus_high,
    input  wire logic         addr16,
    input  wire logic [W-1:0] bus_out,
    // Level comparators of the pins
    input  wire logic [W-1:0] quasi_trip,
    input  wire logic [W-1:0] low_pin_in,
    // Quasi-bidirectional driver enables and bit 0 drive state
    output logic      [W-1:0] strong_pulldown,
    output logic      [W-1:0] transition_pullup,
    output logic      [W-1:0] weak_pullup,
    output logic      [W-1:0] medium_pullup,
    output logic      [1:0]   drive_state0,
    // High-address port enables
    output logic      [W-1:0] hi_pulldown,
    output logic      [W-1:0] hi_strong_pullup,
    output logic      [W-1:0] hi_weak_pullup,
    // Low-address/data port enables
    output logic      [W-1:0] lo_pulldown,
    output logic      [W-1:0] lo_pullup
);
    logic [3:0]   phase_q;
    logic [W-1:0] latch_q;
    logic [W-1:0] hi_latch_q;
    logic [W-1:0] lo_latch_q;
    logic [W-1:0] wr_hold_q;
    logic         wr_pend_q;
    logic [W-1:0] buf_q;
    logic [W-1:0] latch_d;
    logic [W-1:0] buf_d;
    logic [W-1:0] tpu_d;
    logic [W-1:0] trip_s;
    logic [W-1:0] lo_pin_s;
    logic [W-1:0] sample_q;
    logic [W-1:0] prev_q;
    logic [W-1:0] eff;
    logic         s6p2;
    logic         wbus_lo;
    logic         wbus_hi;

    assign s6p2 = (phase_q == `QBP_PH_S6P2);

    // Pin comparator outputs come from outside the clock domain
    qbp_pin_sync #(.W(W)) u_trip_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .clk_en   (clk_en),
        .async_in (quasi_trip),
        .sync_out (trip_s)
    );
    qbp_pin_sync #(.W(W)) u_lo_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .clk_en   (clk_en),
        .async_in (low_pin_in),
        .sync_out (lo_pin_s)
    );

    // Twelve-phase machine cycle counter
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            phase_q <= `QBP_PH_S1P1;
        end else if (clk_en) begin
            if (phase_q == 4'(`QBP_PHASES - 1)) begin // R25
                phase_q <= `QBP_PH_S1P1;
            end else begin
                phase_q <= phase_q + 4'h1;
            end
        end
    end
    assign phase = phase_q;

    // Capture a write request until S6P2
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_q <= 1'b0;
            wr_hold_q <= '0;
        end else if (clk_en) begin
            if (wr_en) begin
                wr_pend_q <= 1'b1;
                wr_hold_q <= wr_data;
            end else if (s6p2) begin
                wr_pend_q <= 1'b0;
            end
        end
    end

    // Next latch value: a held or fresh write lands at S6P2
    always_comb begin
        latch_d = latch_q;
        if (s6p2 && (wr_pend_q || wr_en)) begin // R19
            latch_d = wr_en ? wr_data : wr_hold_q;
        end
    end

    // Port latches load at S6P2; bus use never touches them
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            latch_q    <= `QBP_LATCH_RST; // R2
            hi_latch_q <= `QBP_LATCH_RST; // R2
            lo_latch_q <= `QBP_LATCH_RST; // R2
        end else if (clk_en) begin // R19
            latch_q    <= latch_d;
            hi_latch_q <= latch_d; // R4
            lo_latch_q <= latch_d; // R4
        end
    end

    // Output buffer takes the latch on entry to each phase 1 (even index), holds in phase 2
    assign buf_d = phase_q[0] ? latch_d : buf_q; // R20
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            buf_q <= `QBP_LATCH_RST;
        end else if (clk_en) begin
            buf_q <= buf_d;
        end
    end

    // Latch gates the alternate output; drivers register this next value
    assign eff = buf_d & alt_out; // R1

    // Pulse starts as a 0-to-1 load enters S1P1 and is kept through S1P2
    always_comb begin
        tpu_d = '0;
        if (phase_q == 4'(`QBP_PHASES - 1)) begin
            tpu_d = latch_d & ~latch_q & alt_out; // R10 R14 R17
        end else if (phase_q < 4'(`QBP_PULSE_LEN - 1)) begin
            tpu_d = transition_pullup;
        end
    end

    // Quasi-bidirectional drivers; all switch together so pulldown fights the pulse only if alt_out falls during S1P1
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            strong_pulldown   <= '0;
            transition_pullup <= '0;
            weak_pullup       <= '1; // R16
            medium_pullup     <= '0; // R16
        end else if (clk_en) begin
            strong_pulldown   <= ~eff; // R9
            weak_pullup       <= eff; // R11
            medium_pullup     <= eff & trip_s; // R12
            transition_pullup <= tpu_d; // R10
        end
    end

    // Bit 0 drive state for observation
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            drive_state0 <= 2'(QBP_INPUT_LOW); // R16
        end else if (clk_en) begin
            if (!eff[0]) begin // R13
                drive_state0 <= 2'(QBP_OUTPUT_LOW);
            end else if (tpu_d[0]) begin
                drive_state0 <= 2'(QBP_FORCED_HIGH);
            end else if (trip_s[0]) begin // R15
                drive_state0 <= 2'(QBP_STEADY_HIGH);
            end else begin
                drive_state0 <= 2'(QBP_INPUT_LOW);
            end
        end
    end

    // External bus take-over of both address ports
    assign wbus_lo = ext_bus_low; // R3 R8
    assign wbus_hi = ext_bus_high && addr16; // R24
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hi_pulldown      <= '0;
            hi_strong_pullup <= '0;
            hi_weak_pullup   <= '1;
            lo_pulldown      <= '0;
            lo_pullup        <= '0;
        end else if (clk_en) begin
            if (wbus_hi) begin // R3 R7
                hi_pulldown      <= ~bus_out;
                hi_strong_pullup <= bus_out;
                hi_weak_pullup   <= '0;
            end else begin
                hi_pulldown      <= ~hi_latch_q;
                hi_strong_pullup <= '0;
                hi_weak_pullup   <= hi_latch_q;
            end
            if (wbus_lo) begin // R3 R5
                lo_pulldown <= ~bus_out;
                lo_pullup   <= bus_out;
            end else begin
                lo_pulldown <= ~lo_latch_q; // R6
                lo_pullup   <= '0; // R5
            end
        end
    end

    // Pin sample in S5P1 once per machine cycle, edge against previous
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sample_q <= '1;
            prev_q   <= '1;
            pin_edge <= '0;
            alt_in   <= '1;
        end else if (clk_en) begin
            if (phase_q == `QBP_PH_S5P1) begin // R21
                sample_q <= trip_s & buf_q;
                prev_q   <= sample_q;
                alt_in   <= trip_s & buf_q; // R1
            end
            if (phase_q == `QBP_PH_S5P2) begin
                pin_edge <= sample_q ^ prev_q; // R22
            end else begin
                pin_edge <= '0;
            end
        end
    end

    // Read path: latch or sampled pin
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= `QBP_LATCH_RST;
        end else if (clk_en) begin
            rd_data <= rd_latch_sel ? latch_q : sample_q; // R23
        end
    end

    // Assertions
    chk_pulldown_latch: assert property (@(posedge core_clk) disable iff (!nrst) // R9
        clk_en && phase_q[0] |=> strong_pulldown == ~($past(latch_d) & $past(alt_out)))
        else $error("pulldown does not follow latch");
    chk_pulse_phase: assert property (@(posedge core_clk) disable iff (!nrst) // R10
        (transition_pullup != '0) |-> (phase_q == `QBP_PH_S1P1 || phase_q == `QBP_PH_S1P2))
        else $error("transition pullup outside S1");
    chk_pulse_two: assert property (@(posedge core_clk) disable iff (!nrst) // R10
        clk_en && phase_q == `QBP_PH_S1P2 |-> transition_pullup == $past(transition_pullup))
        else $error("transition pullup not two periods");
    chk_no_repulse: assert property (@(posedge core_clk) disable iff (!nrst) // R14
        clk_en && s6p2 && (latch_d == latch_q) |=> transition_pullup == '0)
        else $error("pulse without zero-to-one load");
    chk_weak_one: assert property (@(posedge core_clk) disable iff (!nrst) // R11
        (strong_pulldown & weak_pullup) == '0)
        else $error("pulldown and weak pullup both on");
    chk_medium_gate: assert property (@(posedge core_clk) disable iff (!nrst) // R12
        (medium_pullup & ~weak_pullup) == '0)
        else $error("medium pullup without latch one");
    chk_lo_open: assert property (@(posedge core_clk) disable iff (!nrst) // R5
        clk_en && !wbus_lo ##1 clk_en |-> lo_pullup == '0)
        else $error("low port pullup outside bus");
    chk_latch_hold: assert property (@(posedge core_clk) disable iff (!nrst) // R19
        !s6p2 |=> $stable(latch_q))
        else $error("latch changed outside S6P2");
    chk_edge_phase: assert property (@(posedge core_clk) disable iff (!nrst) // R22
        (pin_edge != '0) |-> phase_q == `QBP_PH_S5P2 + 4'h1)
        else $error("edge outside sample slot");
    chk_hi_strong: assert property (@(posedge core_clk) disable iff (!nrst) // R7
        clk_en && wbus_hi ##1 clk_en |-> hi_weak_pullup == '0)
        else $error("weak pullup in bus cycle");
    cov_pulse: cover property (@(posedge core_clk) transition_pullup[0]);
    cov_edge: cover property (@(posedge core_clk) pin_edge[0]);
    cov_bus: cover property (@(posedge core_clk) wbus_hi ##1 wbus_lo);
    cov_forced: cover property (@(posedge core_clk) drive_state0 == 2'(QBP_FORCED_HIGH));
endmodule
`default_nettype wire

// ===== hw/qbp_regs.svh
`ifndef QBP_REGS_SVH
`define QBP_REGS_SVH
// Port width and latch reset value (all ones)
`define QBP_WIDTH        8
`define QBP_LATCH_RST    8'hFF
// Machine cycle: 12 oscillator periods, six states of two phases
`define QBP_PHASES       12
// Phase indices within the machine cycle (0 = S1P1)
`define QBP_PH_S1P1      4'h0
`define QBP_PH_S1P2      4'h1
`define QBP_PH_S5P1      4'h8
`define QBP_PH_S5P2      4'h9
`define QBP_PH_S6P2      4'hB
// Transition pullup length in oscillator periods
`define QBP_PULSE_LEN    2
`endif

// ===== testbench/qbp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// Load on the pins: external sinks on the quasi pins, a driver on the low port
module qbp_pin_model (
    // Driver enables from the port
    input  wire logic [7:0] strong_pulldown,
    input  wire logic [7:0] transition_pullup,
    input  wire logic [7:0] weak_pullup,
    input  wire logic [7:0] medium_pullup,
    input  wire logic [7:0] lo_pulldown,
    input  wire logic [7:0] lo_pullup,
    // Commanded external behaviour
    input  wire logic [7:0] ext_low,
    input  wire logic [7:0] lo_ext,
    // Sensed pin levels
    output logic      [7:0] quasi_trip,
    output logic      [7:0] low_pin_in
);
    // Sink or pulldown beats any pullup; the load only sinks, never drives high
    assign quasi_trip = ~strong_pulldown & ~ext_low
                      & (weak_pullup | transition_pullup | medium_pullup);
    // Low port: released pins follow the external driver
    assign low_pin_in = (lo_pullup | lo_ext) & ~lo_pulldown;
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import qbp_pkg::*;
    logic       core_clk, nrst, wr_en, rd_latch_sel, ext_bus_low, ext_bus_high, addr16;
    logic [7:0] wr_data, alt_out, bus_out, ext_low, lo_ext, quasi_trip, low_pin_in;
    logic [7:0] rd_data, pin_edge, alt_in, spd, tpu, wpu, mpu, hpd, hsp, hwp, lpd, lpu;
    logic [7:0] lat, pin, old, rx, wq[$];
    logic [3:0] phase;
    logic [1:0] ds0;
    logic [31:0] rng;
    int         n_fail, n_checks, tp_cnt[8], tp_base[8], ed_cnt[8], ed_base[8];

    qbp_port i_qbp_port (.core_clk(core_clk), .nrst(nrst), .clk_en(1'b1), .wr_en(wr_en),
        .wr_data(wr_data), .rd_latch_sel(rd_latch_sel), .rd_data(rd_data), .pin_edge(pin_edge),
        .phase(phase), .alt_out(alt_out), .alt_in(alt_in), .ext_bus_low(ext_bus_low),
        .ext_bus_high(ext_bus_high), .addr16(addr16), .bus_out(bus_out),
        .quasi_trip(quasi_trip), .low_pin_in(low_pin_in), .strong_pulldown(spd),
        .transition_pullup(tpu), .weak_pullup(wpu), .medium_pullup(mpu), .drive_state0(ds0),
        .hi_pulldown(hpd), .hi_strong_pullup(hsp), .hi_weak_pullup(hwp), .lo_pulldown(lpd),
        .lo_pullup(lpu));
    qbp_pin_model i_qbp_pin_model (.strong_pulldown(spd), .transition_pullup(tpu),
        .weak_pullup(wpu), .medium_pullup(mpu), .lo_pulldown(lpd), .lo_pullup(lpu),
        .ext_low(ext_low), .lo_ext(lo_ext), .quasi_trip(quasi_trip), .low_pin_in(low_pin_in));

    // 20 MHz oscillator clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Running counts of pulse and edge cycles per bit; an unknown adds a big number
    always @(negedge core_clk) begin
        for (int b = 0; b < 8; b++) begin
            tp_cnt[b] += (tpu[b] === 1'b1) ? 1 : (tpu[b] === 1'b0) ? 0 : 100;
            ed_cnt[b] += (pin_edge[b] === 1'b1) ? 1 : (pin_edge[b] === 1'b0) ? 0 : 100;
        end
    end

    function automatic logic [7:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction

    task automatic give_verdict();
        if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chkn(string nm, int e, int g);
        n_checks++;
        if (g != e) begin
            n_fail++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // Bounded wait for a phase index of the machine cycle
    task automatic wait_ph(logic [3:0] p);
        int i;
        for (i = 0; i < 30; i++) begin
            @(negedge core_clk);
            if (phase === p) break;
        end
        if (i == 30) begin
            n_fail++;
            give_verdict();
        end
    endtask

    // Steady drive and read state against the model
    task automatic check_all();
        chk8("weak_pullup", lat, wpu);
        chk8("strong_pulldown", ~lat, spd);
        chk8("medium_pullup", pin, mpu);
        chk8("pin read", pin, rd_data);
        chk8("alt_in", pin, alt_in);
        chk8("drive_state0", {6'h0, lat[0] ? {1'b0, pin[0]} : 2'h3}, {6'h0, ds0});
        @(posedge core_clk) rd_latch_sel <= 1'b1;
        repeat (3) @(negedge core_clk);
        chk8("latch read", lat, rd_data);
        @(posedge core_clk) rd_latch_sel <= 1'b0;
        repeat (3) @(negedge core_clk);
    endtask

    initial begin
        {nrst, wr_en, rd_latch_sel, ext_bus_low, ext_bus_high, addr16} = '0;
        {wr_data, bus_out, ext_low, lo_ext} = '0;
        alt_out = 8'hFF;
        rng = 65;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        @(negedge core_clk);
        chk8("reset weak_pullup", 8'hFF, wpu);
        chk8("reset medium_pullup", 8'h00, mpu);
        chk8("reset drive_state0", 8'h00, {6'h0, ds0});
        repeat (36) @(negedge core_clk);
        lat = 8'hFF;
        pin = 8'hFF;
        wq = '{8'h00, 8'hFF, 8'hFF, 8'h00, xs(), xs(), xs(), xs()};
        foreach (wq[k]) begin
            old = lat;
            wait_ph(4'h3);
            @(posedge core_clk);
            wr_en <= 1'b1;
            wr_data <= wq[k];
            tp_base = tp_cnt;
            @(posedge core_clk) wr_en <= 1'b0;
            lat = wq[k];
            wait_ph(4'hB);
            chk8("pulldown before S1P1", ~old, spd);
            @(negedge core_clk);
            chk8("pulldown at S1P1", ~lat, spd);
            chk8("transition_pullup at S1P1", lat & ~old, tpu);
            repeat (35) @(negedge core_clk);
            for (int b = 0; b < 8; b++) begin
                chkn("pulse length", (!old[b] && lat[b]) ? 2 : 0, tp_cnt[b] - tp_base[b]);
            end
            // Load held for whole machine cycles only
            rx = xs();
            old = lat & ~ext_low;
            @(posedge core_clk) ext_low <= rx;
            pin = lat & ~rx;
            ed_base = ed_cnt;
            repeat (36) @(negedge core_clk);
            for (int b = 0; b < 8; b++) begin
                chkn("pin_edge", int'(old[b] ^ pin[b]), ed_cnt[b] - ed_base[b]);
            end
            check_all();
        end
        // External bus cycle with a wide address
        @(posedge core_clk);
        bus_out <= xs();
        lo_ext <= xs();
        {ext_bus_low, ext_bus_high, addr16} <= 3'b111;
        repeat (24) @(negedge core_clk);
        chk8("lo_pullup bus", bus_out, lpu);
        chk8("lo_pulldown bus", ~bus_out, lpd);
        chk8("hi_strong_pullup", bus_out, hsp);
        chk8("hi_pulldown bus", ~bus_out, hpd);
        @(posedge core_clk) {ext_bus_low, ext_bus_high, addr16} <= 3'b000;
        repeat (24) @(negedge core_clk);
        chk8("lo_pullup io", 8'h00, lpu);
        chk8("lo_pulldown io", ~lat, lpd);
        chk8("hi_weak_pullup io", lat, hwp);
        chk8("hi_pulldown io", ~lat, hpd);
        check_all();
        // Alternate output passes only where the latch holds one
        @(posedge core_clk) alt_out <= xs();
        repeat (24) @(negedge core_clk);
        chk8("alt strong_pulldown", ~(lat & alt_out), spd);
        chk8("alt weak_pullup", lat & alt_out, wpu);
        chk8("alt_in gated", pin & alt_out, alt_in);
        give_verdict();
    end
endmodule
`default_nettype wire
